// >>> verification/scc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module scc_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic select_low_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic last_q;
  logic pin;
  // a released line shows the inverse of its last level, so stale data never passes
  always @(posedge core_clk) begin
    if (serial_out_oe === 1'b1) last_q <= serial_out;
  end
  assign pin = (serial_out_oe === 1'b1) ? serial_out : ~last_q;
  // idle bus: clock low, select high
  initial begin
    sclk = 1'b0;
    select_low_n = 1'b1;
    serial_in = 1'b1;
    last_q = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_clk
  // one frame of nclk clocks, lsb first; hi_end leaves the clock high at select rise
  task automatic xfer(input logic [15:0] word, input int nclk, input bit hi_end, output logic [15:0] resp);
    resp = 16'h0000;
    @(negedge core_clk);
    select_low_n = 1'b0;
    wait_clk(8);
    for (int i = 0; i < nclk; i++) begin
      if (i < 16) resp[i] = pin;
      serial_in = word[i % 16];
      sclk = 1'b1;
      wait_clk(4);
      sclk = 1'b0;
      wait_clk(4);
    end
    if (hi_end) begin
      sclk = 1'b1;
      wait_clk(4);
    end
    select_low_n = 1'b1;
    wait_clk(4);
    sclk = 1'b0;
    serial_in = ~serial_in;
    wait_clk(8);
  endtask : xfer
endmodule : scc_host_model
`default_nettype wire

// >>> verification/spi_command_checker_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, a); end end
module spi_command_checker_bench;
  logic core_clk, rst_n, reset_output_n, sclk, select_low_n, serial_in, serial_out, serial_out_oe;
  logic [7:0] wake_event_one, wake_event_two, wdc, bus1, bus2, wkc2, tper, ton;
  logic [2:0] device_mode;
  logic command_fault, frame_error, wake_interrupt, watchdog_trigger, ls;
  logic [15:0] rsp;
  int bad_count = 0;
  int n_tests = 0;
  int wd_cnt = 0;
  int int_cnt = 0;
  scc_spi_checker u_dut (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .select_low_n(select_low_n),
    .serial_in(serial_in), .reset_output_n(reset_output_n), .wake_event_one(wake_event_one),
    .wake_event_two(wake_event_two), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .device_mode(device_mode), .command_fault(command_fault), .frame_error(frame_error),
    .wake_interrupt(wake_interrupt), .watchdog_trigger(watchdog_trigger), .watchdog_control(wdc),
    .bus_control_one(bus1), .bus_control_two(bus2), .wake_control_two(wkc2), .timer_period(tper),
    .timer_on_time(ton), .regulator3_load_share(ls));
  scc_host_model u_host (.core_clk(core_clk), .sclk(sclk), .select_low_n(select_low_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // pulse outputs last one cycle, so count them on every falling edge
  always @(negedge core_clk) begin
    if (watchdog_trigger === 1'b1) wd_cnt++;
    if (wake_interrupt === 1'b1) int_cnt++;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({d, 1'b1, a}, 16, 1'b0, rsp);
  endtask : wr
  task automatic clr_fault;
    wr(scc_pkg::ADDR_DEV_STAT, 8'h00);
    `CHK("fault cleared", 1'b0, command_fault)
  endtask : clr_fault
  // restart is a fixed span, so the wait is bounded well above it
  task automatic wait_normal;
    int k;
    k = 0;
    while (device_mode !== scc_pkg::MODE_NORMAL && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 200) begin
      bad_count++;
      $display("Error wait_normal expected 1 seen %0h", device_mode);
      end_sim();
    end
  endtask : wait_normal
  initial begin
    rst_n = 1'b0;
    reset_output_n = 1'b1;
    wake_event_one = 8'h00;
    wake_event_two = 8'h00;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("mode", scc_pkg::MODE_INIT, device_mode)
    `CHK("oe idle", 1'b0, serial_out_oe)
    $display("test reset done");
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_STOP, 6'h00});
    `CHK("mode", scc_pkg::MODE_NORMAL, device_mode)
    `CHK("fault", 1'b1, command_fault)
    clr_fault();
    for (int i = 0; i < 2; i++) begin
      u_host.xfer(i ? scc_pkg::WORD_ONES : scc_pkg::WORD_ZEROS, 16, 1'b0, rsp);
      `CHK("stuck fault", 1'b1, command_fault)
      clr_fault();
    end
    $display("test faults done");
    u_host.xfer({8'h05, 1'b1, scc_pkg::ADDR_BUS1}, 8, 1'b0, rsp);
    `CHK("short frame", 1'b1, frame_error)
    `CHK("short discarded", 8'h00, bus1)
    u_host.xfer({8'h00, 1'b0, scc_pkg::ADDR_WD}, 16, 1'b0, rsp);
    `CHK("err bit", 1'b1, rsp[0])
    `CHK("err renewed", 1'b0, frame_error)
    u_host.xfer({8'h00, 1'b0, scc_pkg::ADDR_WD}, 16, 1'b1, rsp);
    `CHK("clock high", 1'b1, frame_error)
    reset_output_n = 1'b0;
    wr(scc_pkg::ADDR_BUS1, 8'h05);
    reset_output_n = 1'b1;
    `CHK("reset low", 1'b1, frame_error)
    `CHK("reset discarded", 8'h00, bus1)
    $display("test frame errors done");
    wr(scc_pkg::ADDR_WD, 8'h01);
    `CHK("wd odd", 8'h00, wdc)
    `CHK("wd odd fault", 1'b1, command_fault)
    clr_fault();
    wr(scc_pkg::ADDR_WD, 8'h03);
    `CHK("wd even", 8'h03, wdc)
    `CHK("wd trig", 1, wd_cnt)
    u_host.xfer({8'h00, 1'b0, scc_pkg::ADDR_WD}, 16, 1'b0, rsp);
    `CHK("read data", 8'h03, rsp[15:8])
    `CHK("read mode", 3'h1, rsp[7:5])
    wr(scc_pkg::ADDR_TMR_PER, 8'h10);
    `CHK("period", 8'h10, tper)
    wr(scc_pkg::ADDR_TMR_ON, 8'h10);
    `CHK("on equal", 8'h00, ton)
    `CHK("on fault", 1'b1, command_fault)
    clr_fault();
    wr(scc_pkg::ADDR_TMR_ON, 8'h0F);
    `CHK("on shorter", 8'h0F, ton)
    wr(7'h1E, 8'h5A);
    `CHK("unused", 1'b0, command_fault)
    $display("test registers done");
    @(negedge core_clk);
    wake_event_one = 8'h01;
    @(negedge core_clk);
    wake_event_one = 8'h00;
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_STOP, 6'h00});
    `CHK("stop", scc_pkg::MODE_STOP, device_mode)
    `CHK("stop fault", 1'b0, command_fault)
    `CHK("stop int", 1, int_cnt)
    wr(scc_pkg::ADDR_BUS2, 8'h05);
    `CHK("stop write", 8'h00, bus2)
    `CHK("stop wr fault", 1'b1, command_fault)
    clr_fault();
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_NORMAL, 6'h01});
    `CHK("to normal", scc_pkg::MODE_NORMAL, device_mode)
    `CHK("bits ignored", 1'b0, ls)
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_STOP, 6'h00});
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_SLEEP, 6'h00});
    `CHK("stop sleep", scc_pkg::MODE_RESTART, device_mode)
    `CHK("stop sleep fault", 1'b1, command_fault)
    u_host.xfer(16'h0081, 0, 1'b0, rsp);
    `CHK("restart deaf", scc_pkg::MODE_RESTART, device_mode)
    `CHK("zero clocks", 1'b0, frame_error)
    wait_normal();
    clr_fault();
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_SLEEP, 6'h00});
    `CHK("no wake src", scc_pkg::MODE_RESTART, device_mode)
    `CHK("no wake fault", 1'b1, command_fault)
    wait_normal();
    clr_fault();
    wr(scc_pkg::ADDR_WKC2, 8'h81);
    `CHK("wkc2", 8'h81, wkc2)
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_SLEEP, 6'h00});
    `CHK("measure", scc_pkg::MODE_RESTART, device_mode)
    `CHK("measure fault", 1'b1, command_fault)
    wait_normal();
    clr_fault();
    $display("test modes done");
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_NORMAL, 6'h01});
    `CHK("share set", 1'b1, ls)
    wr(scc_pkg::ADDR_MODE, {scc_pkg::REQ_NORMAL, 6'h00});
    `CHK("share kept", 1'b1, ls)
    $display("test load share done");
    end_sim();
  end
endmodule : spi_command_checker_bench
`default_nettype wire

// >>> verilog/scc_pkg.sv
`default_nettype none
package scc_pkg;
  // frame geometry
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [3:0] IDX_LAST = 4'hF;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
  localparam logic [15:0] WORD_ZEROS = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  // command word fields
  localparam int ADDR_MSB = 6;
  localparam int WR_BIT = 7;
  localparam int DATA_LSB = 8;
  // control register addresses
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_WD = 7'h02;
  localparam logic [6:0] ADDR_BUS1 = 7'h03;
  localparam logic [6:0] ADDR_BUS2 = 7'h04;
  localparam logic [6:0] ADDR_WKC2 = 7'h05;
  localparam logic [6:0] ADDR_TMR_PER = 7'h06;
  localparam logic [6:0] ADDR_TMR_ON = 7'h07;
  // status register addresses
  localparam logic [6:0] ADDR_DEV_STAT = 7'h43;
  localparam logic [6:0] ADDR_WK_STAT1 = 7'h46;
  localparam logic [6:0] ADDR_WK_STAT2 = 7'h47;
  // mode register: request in bits 7:6, settings in 5:0
  localparam int REQ_LSB = 6;
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SOFTRST = 2'h3;
  localparam int LS_BIT = 0;
  // wake control two fields
  localparam int WK1_BIT = 0;
  localparam int WK2_BIT = 1;
  localparam int MEAS_BIT = 7;
  localparam logic [7:0] WAKE_VOLTAGE_MEASURE_MASK = 8'h83;
  // reset values and timing
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [7:0] RESTART_CYCLES = 8'h40;
  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100
  } scc_mode_t;
endpackage : scc_pkg
`default_nettype wire

// >>> verilog/scc_shift.sv
`timescale 1ns/1ns
`default_nettype none
module scc_shift (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk_s,
  input wire logic sel_n_s,
  input wire logic sin_s,
  output logic [15:0] rx_q,
  output logic [4:0] cnt_q,
  output logic [3:0] bit_idx_q,
  output logic sclk_rise,
  output logic sclk_fall,
  output logic frame_start,
  output logic frame_end,
  output logic clk_hi_edge
);
  logic sclk_p_q;
  logic sel_p_q;
  logic clk_hi_start_q;
  // edge history of the synchronised pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_p_q <= 1'b0;
      sel_p_q <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      sel_p_q <= sel_n_s;
    end
  end
  // clock edges only count while selected
  assign sclk_rise = ~sel_n_s & sclk_s & ~sclk_p_q; // R02
  assign sclk_fall = ~sel_n_s & ~sclk_s & sclk_p_q; // R02
  assign frame_start = ~sel_n_s & sel_p_q;
  assign frame_end = sel_n_s & ~sel_p_q;
  assign clk_hi_edge = clk_hi_start_q | (frame_end & sclk_s); // R22
  // input shift, lsb first; count saturates so long frames stay wrong
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 16'h0000;
      cnt_q <= 5'h00;
      clk_hi_start_q <= 1'b0;
    end else if (frame_start) begin
      rx_q <= 16'h0000;
      cnt_q <= 5'h00;
      clk_hi_start_q <= sclk_s; // R22
    end else if (sclk_fall) begin
      rx_q <= {sin_s, rx_q[15:1]}; // R04
      if (cnt_q != scc_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 5'h01; // R21
      end
    end
  end
  // index of the bit currently on the output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx_q <= 4'h0;
    end else if (frame_start) begin
      bit_idx_q <= 4'h0;
    end else if (sclk_rise && bit_idx_q != scc_pkg::IDX_LAST) begin
      bit_idx_q <= bit_idx_q + 4'h1;
    end
  end
endmodule : scc_shift
`default_nettype wire

// >>> verilog/scc_spi_checker.sv
// Functional notes
// R01 - one 16-bit command in, one response word out, on host clock
// R02 - transfers only while select is low; no response when high
// R03 - select rising interprets the word and releases the output
// R04 - input sampled on each falling serial clock edge
// R05 - next output bit shifted out after each rising clock edge
// R06 - no daisy chain: extra received bits never reach the output
// R07 - wrong commands are ignored and set a sticky fault cleared by host
// R08 - stop to sleep request: fault and enter restart
// R09 - stop or sleep request in init: fault and enter normal
// R10 - odd parity watchdog byte: fault, trigger and settings ignored
// R11 - in stop only trigger, normal, soft reset, reads and clears
// R12 - entering stop with wake status set: interrupt, no fault
// R13 - stop to normal applies only the mode change
// R14 - sleep without any wake source: fault, restart, rest executed
// R15 - stop without wake source accepted silently
// R16 - regulator three load share cannot be cleared once set
// R17 - sleep with measure and only wake one or two: fault, restart
// R18 - timer on-time at or above period: fault
// R19 - all zero or all one frame: fault
// R20 - unused addresses never set the fault
// R21 - clock count not 0 or 16, or reset low: frame error, discard
// R22 - clock high at select edges flagged; error shown before first rise
// R23 - bits 6..0 address, bit 7 write or clear, 15..8 data
// R24 - no command interpreted in restart mode
// R25 - frame error reflects only the previous frame
`timescale 1ns/1ns
`default_nettype none
module scc_spi_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic select_low_n,
  input wire logic serial_in,
  input wire logic reset_output_n,
  input wire logic [7:0] wake_event_one,
  input wire logic [7:0] wake_event_two,
  output logic serial_out,
  output logic serial_out_oe,
  output logic [2:0] device_mode,
  output logic command_fault,
  output logic frame_error,
  output logic wake_interrupt,
  output logic watchdog_trigger,
  output logic [7:0] watchdog_control,
  output logic [7:0] bus_control_one,
  output logic [7:0] bus_control_two,
  output logic [7:0] wake_control_two,
  output logic [7:0] timer_period,
  output logic [7:0] timer_on_time,
  output logic regulator3_load_share
);
  logic sclk_s, sel_n_s, sin_s, ro_s;
  logic [15:0] rx_q;
  logic [4:0] cnt_q;
  logic [3:0] bit_idx_q;
  logic sclk_rise, sclk_fall, frame_start, frame_end, clk_hi_edge;
  scc_pkg::scc_mode_t mode_q, c_mode;
  logic [5:0] ctl_q, c_ctl;
  logic [7:0] wd_q, bus1_q, bus2_q, wkc2_q, per_q, on_q;
  logic [7:0] wk1_q, wk2_q, rd_data;
  logic [15:0] tx_q;
  logic [7:0] rst_cnt_q;
  logic fault_q, err_q, ro_low_q, sout_q, oe_q, int_q, wdt_q;
  logic err_now, exec;
  logic c_fault, c_we, c_clr, c_int;
  logic no_wake, meas_only;
  logic [6:0] addr;
  logic wr;
  logic [7:0] dat;
  logic [1:0] req;

  // the four synchronised pins come from the host or the reset pin: two flops each
  scc_sync #(.W(4), .INIT(4'h7)) u_sync ( // reset pin idles high, so no false reset-low after rst_n
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({sclk, select_low_n, serial_in, reset_output_n}),
    .sync_out({sclk_s, sel_n_s, sin_s, ro_s})
  );

  scc_shift u_shift (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclk_s(sclk_s),
    .sel_n_s(sel_n_s),
    .sin_s(sin_s),
    .rx_q(rx_q),
    .cnt_q(cnt_q),
    .bit_idx_q(bit_idx_q),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .frame_start(frame_start),
    .frame_end(frame_end),
    .clk_hi_edge(clk_hi_edge)
  );

  // word fields of the completed frame
  assign addr = rx_q[scc_pkg::ADDR_MSB:0]; // R23
  assign wr = rx_q[scc_pkg::WR_BIT]; // R23
  assign dat = rx_q[15:scc_pkg::DATA_LSB]; // R23
  assign req = dat[7:scc_pkg::REQ_LSB];

  // frame error: wrong count, clock high at a select edge, reset low
  assign err_now = (cnt_q != scc_pkg::CNT_ZERO && cnt_q != scc_pkg::CNT_FULL)
    | clk_hi_edge | ro_low_q | ~ro_s; // R21 R22
  // only full clean frames are interpreted, never during restart
  assign exec = frame_end & ~err_now & (cnt_q == scc_pkg::CNT_FULL)
    & (mode_q != scc_pkg::MODE_RESTART); // R01 R03 R21 R24

  // remember reset low anywhere inside the frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ro_low_q <= 1'b0;
    end else if (frame_start) begin
      ro_low_q <= ~ro_s; // R21
    end else if (~sel_n_s && ~ro_s) begin
      ro_low_q <= 1'b1; // R21
    end
  end

  // re-judged on every frame end, so it only speaks of the last frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (frame_end) begin
      err_q <= err_now; // R25
    end
  end

  // sleep guards look at the settings in force before this command
  assign no_wake = ~|{bus1_q, bus2_q, wkc2_q};
  assign meas_only = wkc2_q[scc_pkg::MEAS_BIT]
    & (wkc2_q[scc_pkg::WK1_BIT] | wkc2_q[scc_pkg::WK2_BIT])
    & ~|{bus1_q, bus2_q, wkc2_q & ~scc_pkg::WAKE_VOLTAGE_MEASURE_MASK};

  // command checking against the mode state machine
  always_comb begin
    c_fault = 1'b0;
    c_we = 1'b0;
    c_clr = 1'b0;
    c_int = 1'b0;
    c_mode = mode_q;
    c_ctl = ctl_q;
    if (rx_q == scc_pkg::WORD_ZEROS || rx_q == scc_pkg::WORD_ONES) begin
      c_fault = 1'b1; // R19
    end else if (addr[scc_pkg::ADDR_MSB]) begin
      c_clr = wr; // R20
    end else if (wr) begin
      case (addr)
        scc_pkg::ADDR_MODE: begin
          c_we = 1'b1;
          c_ctl = dat[5:0];
          if (ctl_q[scc_pkg::LS_BIT] && !dat[scc_pkg::LS_BIT]) begin
            c_ctl[scc_pkg::LS_BIT] = 1'b1; // R16
          end
          if (mode_q == scc_pkg::MODE_STOP) begin
            c_ctl = ctl_q; // R13
            case (req)
              scc_pkg::REQ_NORMAL: c_mode = scc_pkg::MODE_NORMAL; // R11 R13
              scc_pkg::REQ_SOFTRST: c_mode = scc_pkg::MODE_RESTART; // R11
              scc_pkg::REQ_SLEEP: begin
                c_fault = 1'b1; // R08
                c_mode = scc_pkg::MODE_RESTART; // R08
              end
              default: c_fault = (dat[5:0] != ctl_q); // R11
            endcase
          end else if (mode_q == scc_pkg::MODE_INIT
                       && (req == scc_pkg::REQ_SLEEP || req == scc_pkg::REQ_STOP)) begin
            c_fault = 1'b1; // R09
            c_mode = scc_pkg::MODE_NORMAL; // R09
          end else begin
            case (req)
              scc_pkg::REQ_NORMAL: c_mode = scc_pkg::MODE_NORMAL;
              scc_pkg::REQ_SOFTRST: c_mode = scc_pkg::MODE_RESTART;
              scc_pkg::REQ_STOP: begin
                c_mode = scc_pkg::MODE_STOP; // R15
                c_int = |{wk1_q, wk2_q}; // R12
              end
              default: begin
                if (no_wake || meas_only) begin
                  c_fault = 1'b1; // R14 R17
                  c_mode = scc_pkg::MODE_RESTART; // R14 R17
                end else begin
                  c_mode = scc_pkg::MODE_SLEEP;
                end
              end
            endcase
          end
        end
        scc_pkg::ADDR_WD: begin
          c_fault = ^dat; // R10
          c_we = ~^dat; // R10
        end
        scc_pkg::ADDR_BUS1, scc_pkg::ADDR_BUS2, scc_pkg::ADDR_WKC2: begin
          c_fault = (mode_q == scc_pkg::MODE_STOP); // R11
          c_we = (mode_q != scc_pkg::MODE_STOP); // R07
        end
        scc_pkg::ADDR_TMR_PER, scc_pkg::ADDR_TMR_ON: begin
          if (mode_q == scc_pkg::MODE_STOP) begin
            c_fault = 1'b1; // R11
          end else if (addr == scc_pkg::ADDR_TMR_PER ? on_q >= dat : dat >= per_q) begin
            c_fault = 1'b1; // R18
          end else begin
            c_we = 1'b1;
          end
        end
        default: c_we = 1'b0; // R20
      endcase
    end
  end

  // device mode; restart times out to normal, wake ends sleep
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= scc_pkg::MODE_INIT;
      rst_cnt_q <= 8'h00;
    end else if (mode_q == scc_pkg::MODE_RESTART) begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
      if (rst_cnt_q == scc_pkg::RESTART_CYCLES) begin
        mode_q <= scc_pkg::MODE_NORMAL;
      end
    end else if (exec) begin
      mode_q <= c_mode; // R08 R09 R14 R17
      rst_cnt_q <= 8'h00;
    end else if (mode_q == scc_pkg::MODE_SLEEP && |{wake_event_one, wake_event_two}) begin
      mode_q <= scc_pkg::MODE_RESTART;
    end
  end

  // configuration registers, written only by accepted commands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= scc_pkg::CTL_RESET;
      wd_q <= scc_pkg::CFG_RESET;
      bus1_q <= scc_pkg::CFG_RESET;
      bus2_q <= scc_pkg::CFG_RESET;
      wkc2_q <= scc_pkg::CFG_RESET;
      per_q <= scc_pkg::CFG_RESET;
      on_q <= scc_pkg::CFG_RESET;
    end else if (exec && c_we) begin
      case (addr)
        scc_pkg::ADDR_MODE: ctl_q <= c_ctl; // R13 R14 R16
        scc_pkg::ADDR_WD: wd_q <= dat;
        scc_pkg::ADDR_BUS1: bus1_q <= dat;
        scc_pkg::ADDR_BUS2: bus2_q <= dat;
        scc_pkg::ADDR_WKC2: wkc2_q <= dat;
        scc_pkg::ADDR_TMR_PER: per_q <= dat;
        scc_pkg::ADDR_TMR_ON: on_q <= dat;
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  // sticky flags: a new set in the clearing cycle survives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
      wk1_q <= 8'h00;
      wk2_q <= 8'h00;
    end else begin
      fault_q <= (fault_q & ~(exec & c_clr & addr == scc_pkg::ADDR_DEV_STAT))
        | (exec & c_fault); // R07
      wk1_q <= (wk1_q & ~{8{exec & c_clr & addr == scc_pkg::ADDR_WK_STAT1}}) | wake_event_one;
      wk2_q <= (wk2_q & ~{8{exec & c_clr & addr == scc_pkg::ADDR_WK_STAT2}}) | wake_event_two;
    end
  end

  // one-cycle pulses for watchdog trigger and stop entry interrupt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      wdt_q <= exec & c_we & (addr == scc_pkg::ADDR_WD); // R10
      int_q <= exec & c_int; // R12
    end
  end

  // read data of the register addressed so far in the frame
  always_comb begin
    case (rx_q[15:9])
      scc_pkg::ADDR_MODE: rd_data = {2'b00, ctl_q} | {mode_q[1:0], 6'h00};
      scc_pkg::ADDR_WD: rd_data = wd_q;
      scc_pkg::ADDR_BUS1: rd_data = bus1_q;
      scc_pkg::ADDR_BUS2: rd_data = bus2_q;
      scc_pkg::ADDR_WKC2: rd_data = wkc2_q;
      scc_pkg::ADDR_TMR_PER: rd_data = per_q;
      scc_pkg::ADDR_TMR_ON: rd_data = on_q;
      scc_pkg::ADDR_DEV_STAT: rd_data = {7'h00, fault_q};
      scc_pkg::ADDR_WK_STAT1: rd_data = wk1_q;
      scc_pkg::ADDR_WK_STAT2: rd_data = wk2_q;
      default: rd_data = 8'h00;
    endcase
  end

  // response word; low byte fixed at select fall, high byte once the address is in,
  // before the rise that shifts out bit 8
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 16'h0000;
    end else if (frame_start) begin
      tx_q <= {8'h00, mode_q, |wk1_q, |wk2_q, fault_q, 1'b0, err_q}; // R22
    end else if (~sel_n_s && cnt_q == scc_pkg::CNT_ADDR_DONE) begin
      tx_q[15:8] <= rd_data; // R01
    end
  end

  // output pin: error bit before first rise, high while reset is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (frame_end) begin
      sout_q <= 1'b0;
      oe_q <= 1'b0; // R03
    end else if (frame_start) begin
      sout_q <= err_q | ~ro_s; // R22
      oe_q <= 1'b1; // R02
    end else if (~sel_n_s && ~ro_s) begin
      sout_q <= 1'b1; // R21
    end else if (sclk_rise) begin
      // past bit 15 the line idles low, received bits are never echoed
      sout_q <= (bit_idx_q == scc_pkg::IDX_LAST) ? 1'b0 : tx_q[bit_idx_q + 4'h1]; // R05 R06
    end
  end

  assign serial_out = sout_q;
  assign serial_out_oe = oe_q;
  assign device_mode = mode_q;
  assign command_fault = fault_q;
  assign frame_error = err_q;
  assign wake_interrupt = int_q;
  assign watchdog_trigger = wdt_q;
  assign watchdog_control = wd_q;
  assign bus_control_one = bus1_q;
  assign bus_control_two = bus2_q;
  assign wake_control_two = wkc2_q;
  assign timer_period = per_q;
  assign timer_on_time = on_q;
  assign regulator3_load_share = ctl_q[scc_pkg::LS_BIT];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_mode_wr(logic [1:0] r);
    exec && addr == scc_pkg::ADDR_MODE && wr && req == r && rx_q != scc_pkg::WORD_ONES;
  endsequence

  a_stop_sleep: assert property ( // R08
    s_mode_wr(scc_pkg::REQ_SLEEP) ##0 mode_q == scc_pkg::MODE_STOP
      |=> mode_q == scc_pkg::MODE_RESTART && fault_q)
    else $error("stop to sleep did not fault into restart");
  a_init_lowpow: assert property ( // R09
    s_mode_wr(scc_pkg::REQ_STOP) ##0 mode_q == scc_pkg::MODE_INIT
      |=> mode_q == scc_pkg::MODE_NORMAL && fault_q)
    else $error("init stop request not redirected to normal");
  a_wd_parity: assert property ( // R10
    exec && wr && addr == scc_pkg::ADDR_WD && ^dat |=> fault_q && !watchdog_trigger)
    else $error("odd parity watchdog write accepted");
  a_stuck_word: assert property ( // R19
    exec && rx_q == scc_pkg::WORD_ZEROS |=> fault_q)
    else $error("all zero frame not faulted");
  a_fault_hold: assert property ( // R07
    fault_q && !(exec && wr && addr == scc_pkg::ADDR_DEV_STAT) |=> fault_q)
    else $error("fault flag dropped without clear");
  a_count_err: assert property ( // R21
    frame_end && cnt_q != scc_pkg::CNT_ZERO && cnt_q != scc_pkg::CNT_FULL
      |-> !exec ##1 frame_error)
    else $error("wrong clock count not flagged");
  a_release_out: assert property ( // R03
    frame_end |=> !serial_out_oe [*2])
    else $error("output not released after select rise");
  a_err_first: assert property ( // R22
    frame_start && err_q |=> serial_out until_with (sclk_rise || frame_end))
    else $error("frame error not shown before first rise");
  a_restart_deaf: assert property ( // R24
    mode_q == scc_pkg::MODE_RESTART && frame_end |=> $stable(ctl_q) && $stable(bus1_q) && $stable(fault_q))
    else $error("command interpreted in restart");
  a_ls_hold: assert property ( // R16
    regulator3_load_share |=> regulator3_load_share)
    else $error("load share bit cleared");
endmodule : scc_spi_checker
`default_nettype wire

// >>> verilog/scc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  // two stages; only the second stage is visible to logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : scc_sync
`default_nettype wire
